// [rtl/bmc_pkg.sv]
// Package of shared constants for the battery monitor memory and CRC ends.
package bmc_pkg;
  // Memory geometry.
  localparam int PAGES = 8;
  localparam int PAGE_BYTES = 8;
  // Reflected CRC feedback taps for x^8+x^5+x^4+1.
  localparam logic [7:0] CRC_POLY = 8'h8c;
  localparam logic [7:0] CRC_INIT = 8'h00;
  // Configuration byte fields.
  localparam int CFG_CUR_EN = 0;
  localparam int CFG_ACC_EN = 1;
  localparam int CFG_SHADOW = 2;
  localparam int CFG_VSEL = 3;
  localparam int CFG_TBUSY = 4;
  localparam int CFG_SBUSY = 5;
  localparam int CFG_CBUSY = 6;
  localparam logic [7:0] CFG_RESET = 8'h0f;
  localparam logic [7:0] RSVD_BYTE = 8'hff;
  // Page numbers and byte positions.
  localparam logic [2:0] PG_STATUS = 3'h0;
  localparam logic [2:0] PG_TIME = 3'h1;
  localparam logic [2:0] PG_ACC = 3'h7;
  localparam logic [2:0] BY_THRESH = 3'h7;
  localparam logic [2:0] BY_RSVD = 3'h7;
  // Link commands.
  localparam logic [2:0] CMD_NONE = 3'h0;
  localparam logic [2:0] CMD_WR_SP = 3'h1;
  localparam logic [2:0] CMD_RD_SP = 3'h2;
  localparam logic [2:0] CMD_COPY = 3'h3;
  localparam logic [2:0] CMD_RECALL = 3'h4;
  localparam logic [2:0] CMD_RD_ID = 3'h5;
  localparam logic [2:0] CMD_CONV_T = 3'h6;
  localparam logic [2:0] CMD_CONV_V = 3'h7;
  // Timing at 25 MHz.
  localparam int CLK_HZ = 25000000;
  localparam int COPY_MS = 10;
  localparam int COPY_CYC = CLK_HZ / 1000 * COPY_MS;
  localparam int CONV_MS = 10;
  localparam int CONV_CYC = CLK_HZ / 1000 * CONV_MS;
  localparam int SAMPLE_MHZ = 36410;
  localparam int SAMPLE_CYC = CLK_HZ / SAMPLE_MHZ * 1000;
  // Host register map.
  localparam logic [3:0] HR_CMD = 4'h0;
  localparam logic [3:0] HR_ADDR = 4'h1;
  localparam logic [3:0] HR_WDATA = 4'h2;
  localparam logic [3:0] HR_RDATA = 4'h3;
  localparam logic [3:0] HR_STATUS = 4'h4;
  localparam logic [3:0] HR_CRC = 4'h5;
endpackage

// [rtl/bmc_link_if.sv]
// Interface joining the battery monitor device and its bus master.
`timescale 1ns/1ps
interface bmc_link_if;
  logic [2:0] cmd;      // Command, valid while cmd_valid is high.
  logic cmd_valid;      // One-cycle command strobe from master.
  logic [2:0] page;     // Selected page.
  logic [2:0] byte_idx; // Byte within page for scratchpad writes.
  logic [7:0] wdata;    // Write data byte.
  logic [7:0] rdata;    // Read data byte from device.
  logic rvalid;         // One-cycle pulse per read byte.
  logic busy;           // Device busy with a read stream.
  modport device (input cmd, cmd_valid, page, byte_idx, wdata,
                  output rdata, rvalid, busy);
  modport master (output cmd, cmd_valid, page, byte_idx, wdata,
                  input rdata, rvalid, busy);
endinterface

// [rtl/bmc_device.sv]
// Device end: identity word, paged memory, scratchpads and CRC.
//
// Decided for this implementation: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
module bmc_device #(
  parameter logic [7:0] FAMILY = 8'h5a, // Arbitrary family code.
  parameter logic [47:0] SERIAL = 48'h0123_4567_89ab, // Arbitrary serial.
  parameter int COPY_CYC = bmc_pkg::COPY_CYC,
  parameter int CONV_CYC = bmc_pkg::CONV_CYC,
  parameter int SAMPLE_CYC = bmc_pkg::SAMPLE_CYC
) (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic sys_rst,
  // Link to the master.
  bmc_link_if.device lnk,
  // Measurement inputs.
  input wire logic [15:0] temp_result,
  input wire logic [15:0] volt_result,
  input wire logic [15:0] cur_result,
  // Status outputs.
  output logic sample_tick,
  output logic vsel_supply,
  output logic accum_active
);
  typedef enum logic [1:0] {bmc_idle_t_i, bmc_send, bmc_id} bmc_st_t;
  bmc_st_t st;                          // Read stream state.
  logic [7:0] mem [64];                 // Stored pages.
  logic [7:0] sp [64];                  // Per-page scratchpads.
  logic [2:0] cnt;                      // Byte counter of a stream.
  logic [3:0] rcnt;                     // Stream position.
  logic [7:0] crc;                      // Running CRC of stream.
  logic [2:0] spage;                    // Page being streamed.
  logic [63:0] id_word;                 // Identity word.
  logic [31:0] copy_t, conv_t, samp_t;  // Busy and sampling timers.
  logic temp_busy_flag, storage_busy_flag, converter_busy_flag;
  logic [7:0] integrating_current_accum;
  logic [7:0] cfg_live;

  // Byte-wise CRC step, one bit at a time, LSB first.
  function automatic logic [7:0] crc_byte(input logic [7:0] c,
                                          input logic [7:0] d);
    logic [7:0] r;
    r = c;
    for (int i = 0; i < 8; i++) begin
      r = (r[0] ^ d[i]) ? ((r >> 1) ^ bmc_pkg::CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction

  // Identity CRC from family then serial, starting at zero.
  function automatic logic [7:0] id_crc();
    logic [7:0] c;
    c = bmc_pkg::CRC_INIT;
    c = crc_byte(c, FAMILY);
    for (int k = 0; k < 6; k++) begin
      c = crc_byte(c, SERIAL[k*8 +: 8]);
    end
    return c;
  endfunction

  assign id_word = {id_crc(), SERIAL, FAMILY};

  // Scratchpad configuration byte governs operation.
  assign cfg_live = sp[0];
  wire cur_en = cfg_live[bmc_pkg::CFG_CUR_EN];
  wire acc_en = cfg_live[bmc_pkg::CFG_ACC_EN] & cur_en;
  wire shadow_en = cfg_live[bmc_pkg::CFG_SHADOW] & acc_en;
  wire [7:0] status_configuration = {1'b0, converter_busy_flag,
    storage_busy_flag, temp_busy_flag, cfg_live[3:0]};
  wire [5:0] wr_adr = {lnk.page, lnk.byte_idx};
  wire [5:0] rd_adr = {spage, cnt};
  wire [7:0] sp_rd = (rd_adr == 6'h00) ? status_configuration :
    (rd_adr == {bmc_pkg::PG_TIME, bmc_pkg::BY_RSVD}) ?
      bmc_pkg::RSVD_BYTE : sp[rd_adr];
  wire go = lnk.cmd_valid;
  wire ro_byte = (lnk.page == bmc_pkg::PG_STATUS) &&
    (lnk.byte_idx != 3'h0) && (lnk.byte_idx != bmc_pkg::BY_THRESH);

  // Memory, scratchpad and measurement updates.
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      sp[0] <= bmc_pkg::CFG_RESET;
    end else begin
      if (go && lnk.cmd == bmc_pkg::CMD_WR_SP && !ro_byte) begin
        sp[wr_adr] <= lnk.wdata;
      end
      if (go && lnk.cmd == bmc_pkg::CMD_COPY) begin
        for (int b = 0; b < 8; b++) begin
          mem[{lnk.page, 3'(b)}] <= sp[{lnk.page, 3'(b)}];
        end
      end
      if (go && lnk.cmd == bmc_pkg::CMD_RECALL) begin
        for (int b = 0; b < 8; b++) begin
          sp[{lnk.page, 3'(b)}] <= mem[{lnk.page, 3'(b)}];
        end
      end
      sp[1] <= temp_result[7:0];
      sp[2] <= temp_result[15:8];
      sp[3] <= volt_result[7:0];
      sp[4] <= volt_result[15:8];
      sp[5] <= cur_result[7:0];
      sp[6] <= cur_result[15:8];
      if (sample_tick) begin
        sp[{bmc_pkg::PG_TIME, 3'h4}] <= integrating_current_accum;
      end
      if (sample_tick && shadow_en) begin
        mem[{bmc_pkg::PG_ACC, 3'h4}] <= sp[{bmc_pkg::PG_ACC, 3'h4}];
      end
    end
  end

  // Integrating accumulator and sampling timer.
  assign integrating_current_accum =
    sp[{bmc_pkg::PG_TIME, 3'h4}] + cur_result[7:0];
  always_ff @(posedge clk_sys) begin
    if (sys_rst || !cur_en) begin
      samp_t <= '0;
      sample_tick <= 1'b0;
    end else begin
      sample_tick <= (samp_t == 32'(SAMPLE_CYC - 1));
      samp_t <= (samp_t == 32'(SAMPLE_CYC - 1)) ? '0 : samp_t + 1;
    end
  end

  // Busy flags and their timers.
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      copy_t <= '0;
      conv_t <= '0;
      storage_busy_flag <= 1'b0;
      converter_busy_flag <= 1'b0;
      temp_busy_flag <= 1'b0;
      vsel_supply <= 1'b1;
      accum_active <= 1'b1;
    end else begin
      vsel_supply <= cfg_live[bmc_pkg::CFG_VSEL];
      accum_active <= acc_en;
      if (go && lnk.cmd == bmc_pkg::CMD_COPY && lnk.page > 3'h2) begin
        storage_busy_flag <= 1'b1;
        copy_t <= 32'(COPY_CYC);
      end else if (copy_t != '0) begin
        copy_t <= copy_t - 1;
        storage_busy_flag <= (copy_t != 32'h1);
      end
      if (go && (lnk.cmd == bmc_pkg::CMD_CONV_V ||
                 lnk.cmd == bmc_pkg::CMD_CONV_T)) begin
        conv_t <= 32'(CONV_CYC);
        converter_busy_flag <= (lnk.cmd == bmc_pkg::CMD_CONV_V);
        temp_busy_flag <= (lnk.cmd == bmc_pkg::CMD_CONV_T);
      end else if (conv_t != '0) begin
        conv_t <= conv_t - 1;
        if (conv_t == 32'h1) begin
          converter_busy_flag <= 1'b0;
          temp_busy_flag <= 1'b0;
        end
      end
    end
  end

  // Read streams: eight bytes plus CRC, or the eight identity bytes.
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      st <= bmc_idle_t_i;
      cnt <= '0;
      rcnt <= '0;
      crc <= '0;
      spage <= '0;
      lnk.rdata <= '0;
      lnk.rvalid <= 1'b0;
      lnk.busy <= 1'b0;
    end else begin
      lnk.rvalid <= 1'b0;
      unique case (st)
        bmc_idle_t_i: begin
          cnt <= '0;
          rcnt <= '0;
          crc <= bmc_pkg::CRC_INIT;
          spage <= lnk.page;
          lnk.busy <= go && (lnk.cmd == bmc_pkg::CMD_RD_SP ||
                             lnk.cmd == bmc_pkg::CMD_RD_ID);
          if (go && lnk.cmd == bmc_pkg::CMD_RD_SP) st <= bmc_send;
          if (go && lnk.cmd == bmc_pkg::CMD_RD_ID) st <= bmc_id;
        end
        bmc_send: begin
          lnk.rvalid <= 1'b1;
          rcnt <= rcnt + 4'h1;
          if (rcnt == 4'h8) begin
            lnk.rdata <= crc;
            st <= bmc_idle_t_i;
            lnk.busy <= 1'b0;
          end else begin
            lnk.rdata <= sp_rd;
            crc <= crc_byte(crc, sp_rd);
            cnt <= cnt + 3'h1;
          end
        end
        bmc_id: begin
          lnk.rvalid <= 1'b1;
          lnk.rdata <= id_word[rcnt[2:0]*8 +: 8];
          rcnt <= rcnt + 4'h1;
          if (rcnt == 4'h7) begin
            st <= bmc_idle_t_i;
            lnk.busy <= 1'b0;
          end
        end
        default: st <= bmc_idle_t_i;
      endcase
    end
  end
endmodule

// [rtl/bmc_master.sv]
// Master end: issues link commands from registers and checks CRCs.
`timescale 1ns/1ps
module bmc_master (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic sys_rst,
  // Software register port.
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Link to the device.
  bmc_link_if.master lnk
);
  logic [7:0] addr_r;     // Page and byte select.
  logic [7:0] rbyte;      // Last received byte.
  logic [7:0] crc;        // Running CRC of received bytes.
  logic [7:0] rx_crc;     // Received check byte.
  logic [3:0] nrx;        // Bytes received in this stream.
  logic is_id;            // Stream is an identity read.
  logic crc_bad;          // Sticky mismatch flag.

  // CRC over one byte, shift-right serial form.
  function automatic logic [7:0] crc_byte(input logic [7:0] c,
                                          input logic [7:0] d);
    logic [7:0] r;
    r = c;
    for (int i = 0; i < 8; i++) begin
      r = (r[0] ^ d[i]) ? ((r >> 1) ^ bmc_pkg::CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction

  wire wr_cmd = reg_wr && reg_addr == bmc_pkg::HR_CMD;
  wire last_id = is_id && nrx == 4'h7;
  wire last_sp = !is_id && nrx == 4'h8;
  wire [7:0] status = {5'h0, crc_bad, lnk.busy, 1'b0};
  wire [7:0] rd_mux = (reg_addr == bmc_pkg::HR_ADDR) ? addr_r :
    (reg_addr == bmc_pkg::HR_RDATA) ? rbyte :
    (reg_addr == bmc_pkg::HR_STATUS) ? status :
    (reg_addr == bmc_pkg::HR_CRC) ? rx_crc : 8'h00;

  // Register writes drive the link; a command strobes for one cycle.
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      addr_r <= '0;
      reg_rdata <= '0;
      lnk.cmd <= bmc_pkg::CMD_NONE;
      lnk.cmd_valid <= 1'b0;
      lnk.page <= '0;
      lnk.byte_idx <= '0;
      lnk.wdata <= '0;
    end else begin
      reg_rdata <= reg_rd ? rd_mux : 8'h00;
      lnk.cmd_valid <= wr_cmd;
      if (wr_cmd) lnk.cmd <= reg_wdata[2:0];
      if (reg_wr && reg_addr == bmc_pkg::HR_ADDR) begin
        addr_r <= reg_wdata;
        lnk.page <= reg_wdata[5:3];
        lnk.byte_idx <= reg_wdata[2:0];
      end
      if (reg_wr && reg_addr == bmc_pkg::HR_WDATA) lnk.wdata <= reg_wdata;
    end
  end

  // Receive path and CRC check; mismatch only flags, never stops.
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      crc <= '0;
      rx_crc <= '0;
      nrx <= '0;
      is_id <= 1'b0;
      crc_bad <= 1'b0;
      rbyte <= '0;
    end else begin
      if (wr_cmd) begin
        crc <= bmc_pkg::CRC_INIT;
        nrx <= '0;
        is_id <= reg_wdata[2:0] == bmc_pkg::CMD_RD_ID;
      end else if (lnk.rvalid) begin
        rbyte <= lnk.rdata;
        nrx <= nrx + 4'h1;
        if (last_id || last_sp) begin
          rx_crc <= lnk.rdata;
          crc_bad <= crc_bad | (crc != lnk.rdata);
        end else begin
          crc <= crc_byte(crc, lnk.rdata);
        end
      end
      if (reg_rd && reg_addr == bmc_pkg::HR_STATUS && !lnk.rvalid) begin
        crc_bad <= 1'b0;
      end
    end
  end
endmodule

// [verification/bmc_link_props.sv]
// Checker of read streams on the link between the two ends.
`timescale 1ns/1ps
module bmc_link_props (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic sys_rst,
  // Link signals.
  input wire logic [2:0] cmd,
  input wire logic cmd_valid,
  input wire logic [2:0] page,
  input wire logic [2:0] byte_idx,
  input wire logic [7:0] wdata,
  input wire logic [7:0] rdata,
  input wire logic rvalid,
  input wire logic busy
);
  logic [3:0] n_rx; // Bytes seen in this stream.
  logic [7:0] crc; // CRC over those bytes.
  logic id_rd; // Stream is an identity read.
  logic [2:0] pg; // Page of this stream.
  wire sp_go = cmd_valid && cmd == bmc_pkg::CMD_RD_SP;
  wire id_go = cmd_valid && cmd == bmc_pkg::CMD_RD_ID;
  wire sp_byte = rvalid && !id_rd;
  // One CRC byte step, low bit first, reflected taps.
  function automatic logic [7:0] crc_step(input logic [7:0] c,
                                          input logic [7:0] d);
    for (int i = 0; i < 8; i++) begin
      c = (c[0] ^ d[i]) ? (c >> 1) ^ 8'h8c : c >> 1;
    end
    return c;
  endfunction
  // Follows the byte position and running CRC of each stream.
  always_ff @(posedge clk_sys) begin
    if (sys_rst || sp_go || id_go) begin
      n_rx <= 4'h0;
      crc <= 8'h00;
      id_rd <= id_go;
      pg <= page;
    end else if (rvalid) begin
      n_rx <= n_rx + 4'h1;
      crc <= crc_step(crc, rdata);
    end
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  property p_stream;
    sp_go |=> !rvalid ##1 rvalid [*8] ##1 rvalid ##1 !rvalid;
  endproperty
  a_stream: assert property (p_stream) else $error("bad stream");
  property p_busy;
    sp_go |=> busy [*8] ##1 busy ##1 !busy;
  endproperty
  a_busy: assert property (p_busy) else $error("bad busy");
  property p_rv_busy;
    rvalid |-> $past(busy);
  endproperty
  a_rv_busy: assert property (p_rv_busy) else $error("idle byte");
  property p_hold;
    !rvalid |-> $stable(rdata);
  endproperty
  a_hold: assert property (p_hold) else $error("rdata moved");
  property p_sp_crc;
    sp_byte && n_rx == 4'h8 |-> rdata == crc;
  endproperty
  a_sp_crc: assert property (p_sp_crc) else $error("bad crc");
  property p_id_crc;
    rvalid && id_rd && n_rx == 4'h7 |-> rdata == crc;
  endproperty
  a_id_crc: assert property (p_id_crc) else $error("bad id");
  property p_rsvd;
    sp_byte && pg == 3'h1 && n_rx == 4'h7 |-> rdata == 8'hff;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("bad rsvd");
  property p_cfg7;
    sp_byte && pg == 3'h0 && n_rx == 4'h0 |-> !rdata[7];
  endproperty
  a_cfg7: assert property (p_cfg7) else $error("bad bit7");
endmodule

// [verification/battery_monitor_memory_crc_test.sv]
// Bench joining device and master ends over the link.
`timescale 1ns/1ps
module battery_monitor_memory_crc_test;
  localparam logic [7:0] FAM = 8'h3c; // Arbitrary family code.
  localparam logic [47:0] SER = 48'ha5f0_1e2d_3c4b; // Arbitrary serial.
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic rd_d = 1'b0; // A register answer is due now.
  logic [7:0] reg_rdata;
  logic [15:0] tmp = 16'h0000, vlt = 16'h0000, cur = 16'h0000;
  logic sample_tick, vsel_supply, accum_active;
  int error_cnt = 0;
  int compares = 0;
  int cycles = 0;
  int ticks = 0;
  integer seed = 32'h40db;
  logic [7:0] q_reg[$]; // Expected register answers.
  logic [7:0] q_lnk[$]; // Expected link bytes.
  logic [7:0] sp[8][8]; // Expected scratchpad contents.
  logic [7:0] keep[8]; // Page saved by a copy.
  logic [7:0] c;
  logic [47:0] meas;
  logic [55:0] idw = {SER, FAM};
  bmc_link_if lnk ();
  bmc_device #(.FAMILY(FAM), .SERIAL(SER), .COPY_CYC(20), .CONV_CYC(20),
    .SAMPLE_CYC(10)) bmc_device_i (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .lnk(lnk), .temp_result(tmp), .volt_result(vlt), .cur_result(cur),
    .sample_tick(sample_tick), .vsel_supply(vsel_supply),
    .accum_active(accum_active));
  bmc_master bmc_master_i (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .lnk(lnk));
  bmc_link_props bmc_link_props_i (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .cmd(lnk.cmd), .cmd_valid(lnk.cmd_valid), .page(lnk.page),
    .byte_idx(lnk.byte_idx), .wdata(lnk.wdata), .rdata(lnk.rdata),
    .rvalid(lnk.rvalid), .busy(lnk.busy));
  // Counts a comparison and reports a mismatch.
  task automatic check(input string what, input logic [7:0] seen,
                       input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Prints the counts and the verdict, then stops.
  task automatic final_report();
    $display("compares %0d error_cnt %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // One CRC byte step, low bit first, reflected taps.
  function automatic logic [7:0] crc_step(input logic [7:0] c,
                                          input logic [7:0] d);
    for (int i = 0; i < 8; i++) begin
      c = (c[0] ^ d[i]) ? (c >> 1) ^ 8'h8c : c >> 1;
    end
    return c;
  endfunction
  // Drops both strobes and lets n edges pass.
  task automatic idle(input int n);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    repeat (n) @(posedge clk_sys);
  endtask
  // One register write cycle.
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_rd <= 1'b0;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
  endtask
  // One register read cycle; the answer is noted first.
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    q_reg.push_back(e);
    reg_addr <= a;
    reg_wr <= 1'b0;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
  endtask
  // Sends one link command through the master's registers.
  task automatic link_cmd(input logic [2:0] k, input logic [2:0] p,
                          input logic [2:0] b, input logic [7:0] d);
    wr(bmc_pkg::HR_ADDR, {2'b00, p, b});
    wr(bmc_pkg::HR_WDATA, d);
    wr(bmc_pkg::HR_CMD, {5'h00, k});
    idle(1);
  endtask
  // Writes a scratchpad byte; results and the reserved byte keep theirs.
  task automatic wsp(input logic [2:0] p, input logic [2:0] b,
                     input logic [7:0] d);
    link_cmd(bmc_pkg::CMD_WR_SP, p, b, d);
    if (p != 3'h0 || b == 3'h0 || b == 3'h7) begin
      sp[p][b] = (p == 3'h1 && b == 3'h7) ? 8'hff : d;
    end
  endtask
  // Fills a whole page scratchpad with random bytes.
  task automatic fill(input logic [2:0] p);
    for (int b = 0; b < 8; b++) begin
      wsp(p, b[2:0], 8'($random(seed)));
    end
  endtask
  // Reads a scratchpad page: eight bytes, then their CRC.
  task automatic rd_page(input logic [2:0] p);
    c = 8'h00;
    for (int i = 0; i < 8; i++) begin
      q_lnk.push_back(sp[p][i]);
      c = crc_step(c, sp[p][i]);
    end
    q_lnk.push_back(c);
    link_cmd(bmc_pkg::CMD_RD_SP, p, 3'h0, 8'h00);
    idle(13);
    rd(bmc_pkg::HR_CRC, c);
    rd(bmc_pkg::HR_STATUS, 8'h00);
    idle(1);
  endtask
  // Makes the 25 MHz clock.
  initial begin
    forever #20 clk_sys = ~clk_sys;
  end
  // Compares each answer with the oldest note and cuts a hang short.
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    rd_d <= reg_rd;
    if (sample_tick === 1'b1) begin
      ticks++;
    end
    if (rd_d) begin
      check("reg_rdata", reg_rdata, q_reg.pop_front());
    end
    if (lnk.rvalid === 1'b1) begin
      check("link rdata", lnk.rdata, q_lnk.pop_front());
    end
    if (cycles == 40000) begin
      error_cnt++;
      final_report();
    end
  end
  // Main sequence.
  initial begin
    repeat (3) @(posedge clk_sys);
    sys_rst <= 1'b0;
    idle(2);
    check("vsel_supply", {7'h00, vsel_supply}, 8'h01);
    check("accum_active", {7'h00, accum_active}, 8'h01);
    ticks = 0;
    idle(50);
    check("ticks on", 8'(ticks / 4), 8'h01);
    wsp(3'h0, 3'h0, 8'h00);
    idle(4);
    ticks = 0;
    idle(40);
    check("ticks off", 8'(ticks), 8'h00);
    check("vsel_supply", {7'h00, vsel_supply}, 8'h00);
    check("accum_active", {7'h00, accum_active}, 8'h00);
    c = 8'h00;
    for (int i = 0; i < 7; i++) begin
      q_lnk.push_back(idw[8*i +: 8]);
      c = crc_step(c, idw[8*i +: 8]);
    end
    q_lnk.push_back(c);
    link_cmd(bmc_pkg::CMD_RD_ID, 3'h0, 3'h0, 8'h00);
    // The stream has just started, so the busy bit must show.
    rd(bmc_pkg::HR_STATUS, 8'h02);
    idle(19);
    rd(bmc_pkg::HR_CRC, c);
    wr(4'he, 8'h5a);
    rd(4'he, 8'h00);
    rd(4'hf, 8'h00);
    idle(2);
    for (int p = 1; p < 8; p++) begin
      fill(p[2:0]);
      rd_page(p[2:0]);
      keep = sp[p];
      link_cmd(bmc_pkg::CMD_COPY, p[2:0], 3'h0, 8'h00);
      idle(25);
      fill(p[2:0]);
      rd_page(p[2:0]);
      link_cmd(bmc_pkg::CMD_RECALL, p[2:0], 3'h0, 8'h00);
      idle(4);
      sp[p] = keep;
      rd_page(p[2:0]);
    end
    meas = {16'($random(seed)), 32'($random(seed))};
    {cur, vlt, tmp} <= meas;
    for (int i = 0; i < 6; i++) begin
      sp[0][i + 1] = meas[8*i +: 8];
    end
    wsp(3'h0, 3'h0, 8'h03);
    wsp(3'h0, 3'h3, 8'h77);
    wsp(3'h0, 3'h7, 8'($random(seed)));
    idle(4);
    check("vsel_supply", {7'h00, vsel_supply}, 8'h00);
    check("accum_active", {7'h00, accum_active}, 8'h01);
    for (int k = 0; k < 3; k++) begin
      link_cmd(k == 0 ? bmc_pkg::CMD_CONV_T : k == 1 ? bmc_pkg::CMD_CONV_V
               : bmc_pkg::CMD_COPY, 3'h3, 3'h0, 8'h00);
      sp[0][0] = 8'h03 | (k == 0 ? 8'h10 : k == 1 ? 8'h40 : 8'h20);
      rd_page(3'h0);
      idle(25);
    end
    sp[0][0] = 8'h03;
    rd_page(3'h0);
    idle(5);
    // With shadowing on, the page 7 accumulator byte reaches storage.
    wsp(3'h0, 3'h0, 8'h07);
    wsp(3'h7, 3'h4, 8'h5c);
    idle(12);
    // Shadowing off again, so the later byte stays in the scratchpad.
    wsp(3'h0, 3'h0, 8'h03);
    wsp(3'h7, 3'h4, 8'ha3);
    link_cmd(bmc_pkg::CMD_RECALL, 3'h7, 3'h0, 8'h00);
    idle(4);
    sp[7][4] = 8'h5c;
    rd_page(3'h7);
    rd_page(3'h0);
    idle(5);
    check("pending", 8'(q_lnk.size() + q_reg.size()), 8'h00);
    final_report();
  end
endmodule
